// *** shared/uhrp_defines.svh ***
`ifndef UHRP_DEFINES_SVH
`define UHRP_DEFINES_SVH

// ***************
// Register indices (byte address = index * 4)
// ***************
`define UHRP_P0_DATA_IDX 8'hC0
`define UHRP_P0_ENABLES_IDX 8'hC1
`define UHRP_P1_DATA_IDX 8'hD0
`define UHRP_P1_ENABLES_IDX 8'hD1
`define UHRP_OFS_FIFO 8'h02
`define UHRP_OFS_LINE 8'h03
`define UHRP_OFS_STAT 8'h04

// ***************
// Field positions
// ***************
`define UHRP_ENABLES_USED 5
`define UHRP_LINE_DLAB 7
`define UHRP_FIFO_EN 0
`define UHRP_FIFO_CLR_RX 1
`define UHRP_FIFO_CLR_TX 2
`define UHRP_ST_RXD 0
`define UHRP_ST_TXE 1
`define UHRP_ST_LINE 2
`define UHRP_ST_MODEM 3
`define UHRP_ST_TXC 4
`define UHRP_ST_TOUT 5

// ***************
// Reset values and sizes
// ***************
`define UHRP_ENABLES_RST 8'h00
`define UHRP_LINE_RST 8'h00
`define UHRP_DIV_LO_RST 8'h02
`define UHRP_DIV_HI_RST 8'h00
`define UHRP_FIFO_DEPTH 5'h10
`define UHRP_SINGLE_DEPTH 5'h01

// ***************
// Pending source codes
// ***************
`define UHRP_CODE_LINE 3'h3
`define UHRP_CODE_RXD 3'h2
`define UHRP_CODE_TOUT 3'h6
`define UHRP_CODE_TXC 3'h5
`define UHRP_CODE_TXE 3'h1
`define UHRP_CODE_MODEM 3'h0

`endif

// *** shared/uhrp_pkg.sv ***
`default_nettype none
package uhrp_pkg;
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_DATA = 4'h4,
		TX_STOP = 4'h8
	} uhrp_tx_state_t;
endpackage
`default_nettype wire

// *** rtl/uhrp_core.sv ***
// Summary of operation
// (RL1) Reset returns all registers to defaults; interrupt enables clear to zero.
// (RL2) Writes to unused registers or bits are ignored; such reads return zero.
// (RL3) Software writes zero to reserved bits, including enable bits 7 to 5.
// (RL4) Short characters transmit only the low bits of the written byte.
// (RL5) Transmit port feeds a 16-byte FIFO; one byte deep when FIFO is off.
// (RL6) Short received characters sit in low bits, upper bits read zero.
// (RL7) Receive port reads the receive FIFO; one byte deep when FIFO is off.
// (RL8) Data ports and divisor low byte share index C0h, port 1 D0h.
// (RL9) Interrupt enables and divisor high byte share index C1h, port 1 D1h.
// (RL10) Enable bit 4 raises transmission complete when holding and shifter empty.
// (RL11) Enable bit 3 raises modem interrupt on any modem status input edge.
// (RL12) Enable bit 2 raises line interrupt on parity, framing, overrun, break.
// (RL13) Enable bit 1 raises transmit interrupt when transmit storage is empty.
// (RL14) Enable bit 0 enables receive data and receiver time-out interrupts.
// (RL15) Line control bit 7 steers shared indices to divisor bytes; resets to 0.
// (RL16) Only the highest-priority pending enabled source is reported.
// (RL17) Receive read pops the oldest byte; transmit write appends one byte.
// (RL18) Interrupt output stays high while any enabled source is pending.
//
// Design decision made here: register access over APB.
`include "uhrp_defines.svh"
`default_nettype none
module uhrp_core #(
	parameter bit PORT = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic txd,
	output logic baud_tick,
	output logic [1:0] char_len,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_parity_err,
	input wire logic rx_framing_err,
	input wire logic rx_break,
	input wire logic rx_timeout,
	input wire logic [3:0] modem_status,
	output logic irq
);
	// ***************
	// Bus decode
	// ***************
	logic [7:0] base;
	logic [7:0] idx;
	logic acc_wr;
	logic setup;
	logic hit_data, hit_ier, hit_fifo, hit_line, hit_stat;
	logic dlab;
	logic [7:0] interrupt_enables;
	logic [7:0] line_control;
	logic [7:0] divisor_low_byte;
	logic [7:0] divisor_high_byte;
	logic fifo_en;
	logic [5:0] status;
	logic [5:0] pending;
	logic [2:0] pending_source_code;
	logic [4:0] cap;

	assign base = PORT ? `UHRP_P1_DATA_IDX : `UHRP_P0_DATA_IDX;
	assign idx = paddr[9:2];
	assign setup = psel & ~penable;
	assign acc_wr = psel & penable & pwrite;
	assign hit_data = (idx == base); // see (RL8)
	assign hit_ier = (idx == base + 8'h01); // see (RL9)
	assign hit_fifo = (idx == base + `UHRP_OFS_FIFO);
	assign hit_line = (idx == base + `UHRP_OFS_LINE);
	assign hit_stat = (idx == base + `UHRP_OFS_STAT);
	assign dlab = line_control[`UHRP_LINE_DLAB]; // see (RL15)
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign char_len = line_control[1:0];
	assign cap = fifo_en ? `UHRP_FIFO_DEPTH : `UHRP_SINGLE_DEPTH; // see (RL5)

	// ***************
	// Configuration registers
	// ***************
	logic div_wr;
	assign div_wr = acc_wr & dlab & (hit_data | hit_ier);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enables <= `UHRP_ENABLES_RST; // see (RL1)
			line_control <= `UHRP_LINE_RST; // see (RL15)
			divisor_low_byte <= `UHRP_DIV_LO_RST;
			divisor_high_byte <= `UHRP_DIV_HI_RST;
			fifo_en <= 1'b0;
		end else if (acc_wr) begin
			if (hit_ier && !dlab)
				interrupt_enables <= {3'b000, pwdata[4:0]}; // see (RL2)
			if (hit_ier && dlab)
				divisor_high_byte <= pwdata[7:0];
			if (hit_data && dlab)
				divisor_low_byte <= pwdata[7:0];
			if (hit_line)
				line_control <= pwdata[7:0];
			if (hit_fifo)
				fifo_en <= pwdata[`UHRP_FIFO_EN];
		end
	end

	// ***************
	// Baud divider
	// ***************
	logic [15:0] baud_cnt;
	assign baud_tick = (baud_cnt == 16'h0001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			baud_cnt <= 16'h0000;
		else if (div_wr)
			baud_cnt <= 16'h0000;
		else if (baud_cnt == 16'h0000 || baud_tick)
			baud_cnt <= {divisor_high_byte, divisor_low_byte};
		else
			baud_cnt <= baud_cnt - 16'h0001;
	end

	// ***************
	// Transmit FIFO
	// ***************
	logic [7:0] tx_mem [16];
	logic [3:0] tx_wp, tx_rp;
	logic [4:0] tx_cnt;
	logic tx_push, tx_pop, tx_clr;
	logic rx_clr;

	assign tx_clr = acc_wr & hit_fifo & pwdata[`UHRP_FIFO_CLR_TX];
	assign rx_clr = acc_wr & hit_fifo & pwdata[`UHRP_FIFO_CLR_RX];
	// A byte written while storage is full is dropped
	assign tx_push = acc_wr & hit_data & ~dlab & (tx_cnt < cap); // see (RL17)

	always_ff @(posedge pclk) begin
		if (tx_push)
			tx_mem[tx_wp] <= pwdata[7:0]; // see (RL5)
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wp <= 4'h0;
			tx_rp <= 4'h0;
			tx_cnt <= 5'h00;
		end else if (tx_clr) begin
			tx_wp <= 4'h0;
			tx_rp <= 4'h0;
			tx_cnt <= 5'h00;
		end else begin
			if (tx_push)
				tx_wp <= tx_wp + 4'h1;
			if (tx_pop)
				tx_rp <= tx_rp + 4'h1;
			if (tx_push && !tx_pop)
				tx_cnt <= tx_cnt + 5'h01;
			else if (tx_pop && !tx_push)
				tx_cnt <= tx_cnt - 5'h01;
		end
	end

	// ***************
	// Transmit shifter
	// ***************
	uhrp_pkg::uhrp_tx_state_t tx_state;
	logic [7:0] tx_shift;
	logic [2:0] tx_bit;
	logic [2:0] last_bit;

	assign last_bit = {1'b1, char_len}; // Last data bit index, 4 to 7
	assign tx_pop = (tx_state == uhrp_pkg::TX_IDLE) & (tx_cnt != 5'h00)
		& ~tx_clr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= uhrp_pkg::TX_IDLE;
			tx_shift <= 8'h00;
			tx_bit <= 3'h0;
			txd <= 1'b1;
		end else begin
			case (tx_state)
			uhrp_pkg::TX_IDLE: begin
				// Start bit leaves with the load, so no tick misses it
				txd <= ~tx_pop;
				if (tx_pop) begin
					tx_shift <= tx_mem[tx_rp];
					tx_state <= uhrp_pkg::TX_START;
				end
			end
			uhrp_pkg::TX_START: begin
				txd <= 1'b0;
				if (baud_tick) begin
					tx_bit <= 3'h0;
					tx_state <= uhrp_pkg::TX_DATA;
				end
			end
			uhrp_pkg::TX_DATA: begin
				txd <= tx_shift[0];
				if (baud_tick) begin
					tx_shift <= {1'b0, tx_shift[7:1]};
					tx_bit <= tx_bit + 3'h1;
					// Upper bits of short characters are never sent
					if (tx_bit == last_bit) // see (RL4)
						tx_state <= uhrp_pkg::TX_STOP;
				end
			end
			uhrp_pkg::TX_STOP: begin
				txd <= 1'b1;
				if (baud_tick)
					tx_state <= uhrp_pkg::TX_IDLE;
			end
			default: tx_state <= uhrp_pkg::TX_IDLE;
			endcase
		end
	end

	// ***************
	// Receive FIFO
	// ***************
	logic [7:0] rx_mem [16];
	logic [3:0] rx_wp, rx_rp;
	logic [4:0] rx_cnt;
	logic rx_push, rx_pop, rx_pop_arm, overrun;
	logic [7:0] rx_mask;

	assign rx_push = rx_byte_valid & (rx_cnt < cap) & ~rx_clr; // see (RL7)
	assign overrun = rx_byte_valid & (rx_cnt >= cap);
	// Pop only a byte that was visible when read data was captured
	assign rx_pop = psel & penable & ~pwrite & hit_data & ~dlab
		& rx_pop_arm; // see (RL17)
	assign rx_mask = 8'hFF >> (2'h3 - char_len);

	always_ff @(posedge pclk) begin
		if (rx_push)
			rx_mem[rx_wp] <= rx_byte;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wp <= 4'h0;
			rx_rp <= 4'h0;
			rx_cnt <= 5'h00;
		end else if (rx_clr) begin
			rx_wp <= 4'h0;
			rx_rp <= 4'h0;
			rx_cnt <= 5'h00;
		end else begin
			if (rx_push)
				rx_wp <= rx_wp + 4'h1;
			if (rx_pop)
				rx_rp <= rx_rp + 4'h1;
			if (rx_push && !rx_pop)
				rx_cnt <= rx_cnt + 5'h01;
			else if (rx_pop && !rx_push)
				rx_cnt <= rx_cnt - 5'h01;
		end
	end

	// ***************
	// Interrupt events and status
	// ***************
	logic [3:0] modem_prev;
	logic tx_empty_prev, tx_done_prev;
	logic tx_empty, tx_done;
	logic [5:0] set_ev, clr_ev, mask;

	assign tx_empty = (tx_cnt == 5'h00);
	assign tx_done = tx_empty & (tx_state == uhrp_pkg::TX_IDLE);
	assign set_ev[`UHRP_ST_RXD] = rx_push; // see (RL14)
	assign set_ev[`UHRP_ST_TXE] = tx_empty & ~tx_empty_prev; // see (RL13)
	assign set_ev[`UHRP_ST_LINE] = overrun | (rx_byte_valid
		& (rx_parity_err | rx_framing_err | rx_break)); // see (RL12)
	assign set_ev[`UHRP_ST_MODEM] = |(modem_status ^ modem_prev); // see (RL11)
	assign set_ev[`UHRP_ST_TXC] = tx_done & ~tx_done_prev; // see (RL10)
	assign set_ev[`UHRP_ST_TOUT] = rx_timeout; // see (RL14)
	assign clr_ev = (acc_wr & hit_stat) ? pwdata[5:0] : 6'h00;
	assign mask = {interrupt_enables[0], interrupt_enables[4:0]};
	assign pending = status & mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_prev <= 4'h0;
			tx_empty_prev <= 1'b1;
			tx_done_prev <= 1'b1;
		end else begin
			modem_prev <= modem_status;
			tx_empty_prev <= tx_empty;
			tx_done_prev <= tx_done;
		end
	end

	// Set wins over a simultaneous write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status <= 6'h00;
		else
			status <= (status & ~clr_ev) | set_ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |pending; // see (RL18)
	end

	always_comb begin
		if (pending[`UHRP_ST_LINE]) // see (RL16)
			pending_source_code = `UHRP_CODE_LINE;
		else if (pending[`UHRP_ST_RXD])
			pending_source_code = `UHRP_CODE_RXD;
		else if (pending[`UHRP_ST_TOUT])
			pending_source_code = `UHRP_CODE_TOUT;
		else if (pending[`UHRP_ST_TXC])
			pending_source_code = `UHRP_CODE_TXC;
		else if (pending[`UHRP_ST_TXE])
			pending_source_code = `UHRP_CODE_TXE;
		else
			pending_source_code = `UHRP_CODE_MODEM;
	end

	// ***************
	// Read data, captured in the setup cycle
	// ***************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			rx_pop_arm <= 1'b0;
		end else if (setup) begin
			rx_pop_arm <= hit_data & ~dlab & ~pwrite & (rx_cnt != 5'h00);
			prdata <= 32'h0000_0000; // see (RL2)
			if (!pwrite) begin
				if (hit_data && dlab)
					prdata[7:0] <= divisor_low_byte;
				else if (hit_data && rx_cnt != 5'h00)
					prdata[7:0] <= rx_mem[rx_rp] & rx_mask; // see (RL6)
				else if (hit_ier && dlab)
					prdata[7:0] <= divisor_high_byte;
				else if (hit_ier)
					prdata[7:0] <= interrupt_enables;
				else if (hit_fifo)
					prdata[7:0] <= {fifo_en, 3'b000,
						pending_source_code, ~|pending};
				else if (hit_line)
					prdata[7:0] <= line_control;
				else if (hit_stat)
					prdata[5:0] <= status;
			end
		end
	end
endmodule // uhrp_core
`default_nettype wire

// *** verif/uhrp_properties.sv ***
`default_nettype none
module uhrp_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] char_len,
	input wire logic rx_byte_valid,
	input wire logic rx_parity_err,
	input wire logic [3:0] modem_status,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic acc;
	logic rd;
	logic dlab;
	logic [4:0] ien;
	assign acc = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	// *****
	// Shadow of divisor access and enables
	// *****
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dlab <= 1'h0;
		else if (acc && paddr == 10'h30C)
			dlab <= pwdata[7];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ien <= 5'h00;
		else if (acc && paddr == 10'h304 && !dlab)
			ien <= pwdata[4:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	zero_wait_a: assert property (pready && !pslverr)
		else $error("answer not zero wait");
	unmapped_zero_a: assert property (rd &&
		!(paddr[9:2] inside {[8'hC0:8'hC4]}) |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	high_zero_a: assert property (prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	ien_read_a: assert property (rd && paddr == 10'h304 && !dlab
		|=> prdata[7:0] == {3'h0, $past(ien)})
		else $error("enable readback wrong");
	rx_irq_a: assert property (rx_byte_valid && ien[0] |-> ##2 irq)
		else $error("rx irq missing");
	line_irq_a: assert property (
		rx_byte_valid && rx_parity_err && ien[2] |-> ##2 irq)
		else $error("line irq missing");
	modem_irq_a: assert property (
		!$stable(modem_status) && ien[3] |-> ##2 irq)
		else $error("modem irq missing");
	irq_fall_a: assert property ($fell(irq) |->
		$past(acc) || $past(acc, 2) || $past(acc, 3))
		else $error("irq fell without service");
	char_len_a: assert property (acc && paddr == 10'h30C
		|=> char_len == $past(pwdata[1:0]))
		else $error("char length not taken");
	rst_clear_a: assert property ($rose(presetn) |->
		!irq && prdata == 32'h0)
		else $error("reset values wrong");
endmodule // uhrp_properties
bind uhrp_core uhrp_properties uhrp_properties_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.char_len(char_len),
	.rx_byte_valid(rx_byte_valid),
	.rx_parity_err(rx_parity_err),
	.modem_status(modem_status),
	.irq(irq)
);
`default_nettype wire

// *** verif/uhrp_peer.sv ***
`default_nettype none
module uhrp_peer (
	input wire logic pclk,
	input wire logic txd,
	input wire logic baud_tick,
	input wire logic [1:0] char_len,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic rx_parity_err
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got [$];
	logic [7:0] sh;
	int n = 0;
	initial begin
		rx_byte_valid = 1'h0;
		rx_byte = 8'h00;
		rx_parity_err = 1'h0;
	end
	// *****
	// Line decode: each bit is taken at the tick that ends it
	// *****
	always @(posedge pclk) begin
		if (baud_tick) begin
			if (n == 0 && !txd) begin
				n = 1;
				sh = 8'h00;
			end else if (n > 0 && n <= char_len + 5) begin
				sh[n - 1] = txd;
				n++;
			end else if (n > 0) begin
				got.push_back(sh);
				n = 0;
			end
		end
	end
	// Released lines show the inverse, never the old value
	task automatic send(input logic [7:0] b, input logic pe);
		@(posedge pclk);
		rx_byte_valid <= 1'h1;
		rx_byte <= b;
		rx_parity_err <= pe;
		@(posedge pclk);
		rx_byte_valid <= 1'h0;
		rx_byte <= ~b;
		rx_parity_err <= ~pe;
	endtask
endmodule // uhrp_peer
`default_nettype wire

// *** verif/uart_host_register_port_test.sv ***
`default_nettype none
module uart_host_register_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [9:0] A_DATA = 10'h300;
	localparam logic [9:0] A_IEN = 10'h304;
	localparam logic [9:0] A_FIFO = 10'h308;
	localparam logic [9:0] A_LINE = 10'h30C;
	localparam logic [9:0] A_STAT = 10'h310;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic txd, baud_tick, irq, rx_byte_valid, rx_parity_err;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0] char_len;
	logic [7:0] rx_byte;
	logic [3:0] modem_status;
	logic rx_framing_err = 1'h0;
	logic rx_break = 1'h0;
	logic rx_timeout = 1'h0;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	uhrp_core uhrp_core_i (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.txd(txd),
		.baud_tick(baud_tick),
		.char_len(char_len),
		.rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte),
		.rx_parity_err(rx_parity_err),
		.rx_framing_err(rx_framing_err),
		.rx_break(rx_break),
		.rx_timeout(rx_timeout),
		.modem_status(modem_status),
		.irq(irq)
	);
	uhrp_peer uhrp_peer_i (
		.pclk(pclk),
		.txd(txd),
		.baud_tick(baud_tick),
		.char_len(char_len),
		.rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte),
		.rx_parity_err(rx_parity_err)
	);
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// *****
	// Bus and scenarios
	// *****
	task automatic apb(input logic w, input logic [9:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic tx_check(input logic [7:0] exp);
		int k = 0;
		while (uhrp_peer_i.got.size() == 0 && k < 2000) begin
			@(posedge pclk);
			k++;
		end
		chk("tx byte", {24'h0, uhrp_peer_i.got.pop_front()}, {24'h0, exp});
	endtask
	task automatic t_map;
		apb(1'h0, A_IEN, 8'h00);
		chk("ien reset", r, 32'h0);
		apb(1'h1, 10'h3FC, 8'hFF);
		apb(1'h0, 10'h3FC, 8'h00);
		chk("unmapped", r, 32'h0);
		apb(1'h1, A_IEN, 8'h1F);
		apb(1'h0, A_IEN, 8'h00);
		chk("ien", r, 32'h1F);
		apb(1'h1, A_LINE, 8'h83);
		apb(1'h1, A_DATA, 8'h05);
		apb(1'h0, A_DATA, 8'h00);
		chk("div low", r, 32'h5);
		apb(1'h0, A_IEN, 8'h00);
		chk("div high", r, 32'h0);
		apb(1'h1, A_LINE, 8'h03);
		apb(1'h0, A_IEN, 8'h00);
		chk("ien kept", r, 32'h1F);
	endtask
	task automatic t_tx;
		apb(1'h1, A_IEN, 8'h12);
		apb(1'h1, A_DATA, 8'hA5);
		tx_check(8'hA5);
		apb(1'h1, A_LINE, 8'h00);
		apb(1'h1, A_DATA, 8'hF6);
		tx_check(8'h16);
		apb(1'h1, A_LINE, 8'h03);
		apb(1'h1, A_FIFO, 8'h01);
		for (int i = 1; i < 4; i++)
			apb(1'h1, A_DATA, 8'(i * 17));
		for (int i = 1; i < 4; i++)
			tx_check(8'(i * 17));
		repeat (8) @(posedge pclk);
		apb(1'h0, A_STAT, 8'h00);
		chk("tx status", r & 32'h12, 32'h12);
		chk("tx irq", {31'h0, irq}, 32'h1);
	endtask
	task automatic t_rx;
		apb(1'h1, A_FIFO, 8'h06);
		apb(1'h1, A_IEN, 8'h00);
		apb(1'h1, A_STAT, 8'h3F);
		uhrp_peer_i.send(8'h3C, 1'h0);
		uhrp_peer_i.send(8'h5A, 1'h0);
		apb(1'h0, A_DATA, 8'h00);
		chk("rx single", r, 32'h3C);
		apb(1'h0, A_STAT, 8'h00);
		chk("overrun", r & 32'h5, 32'h5);
		apb(1'h0, A_DATA, 8'h00);
		chk("rx empty", r, 32'h0);
		chk("masked irq", {31'h0, irq}, 32'h0);
		apb(1'h1, A_FIFO, 8'h01);
		for (int i = 1; i < 4; i++)
			uhrp_peer_i.send(8'(i * 9), 1'h0);
		for (int i = 1; i < 4; i++) begin
			apb(1'h0, A_DATA, 8'h00);
			chk("rx fifo", r, 32'(i * 9));
		end
	endtask
	task automatic t_irq;
		apb(1'h1, A_STAT, 8'h3F);
		apb(1'h1, A_IEN, 8'h05);
		uhrp_peer_i.send(8'h77, 1'h1);
		repeat (3) @(posedge pclk);
		chk("irq set", {31'h0, irq}, 32'h1);
		apb(1'h0, A_FIFO, 8'h00);
		chk("line code", r & 32'hF, 32'h6);
		apb(1'h1, A_STAT, 8'h04);
		apb(1'h0, A_FIFO, 8'h00);
		chk("rx code", r & 32'hF, 32'h4);
		apb(1'h0, A_DATA, 8'h00);
		apb(1'h1, A_STAT, 8'h3F);
		repeat (2) @(posedge pclk);
		chk("irq clear", {31'h0, irq}, 32'h0);
		apb(1'h1, A_IEN, 8'h08);
		modem_status <= 4'h5;
		repeat (3) @(posedge pclk);
		chk("modem irq", {31'h0, irq}, 32'h1);
		apb(1'h0, A_FIFO, 8'h00);
		chk("modem code", r & 32'hF, 32'h0);
	endtask
	task automatic t_err;
		apb(1'h1, A_FIFO, 8'h03);
		apb(1'h1, A_STAT, 8'h3F);
		apb(1'h1, A_IEN, 8'h04);
		rx_framing_err <= 1'h1;
		uhrp_peer_i.send(8'h11, 1'h0);
		rx_framing_err <= 1'h0;
		apb(1'h0, A_FIFO, 8'h00);
		chk("framing code", r & 32'hF, 32'h6);
		apb(1'h1, A_STAT, 8'h3F);
		rx_break <= 1'h1;
		uhrp_peer_i.send(8'h22, 1'h0);
		rx_break <= 1'h0;
		apb(1'h0, A_STAT, 8'h00);
		chk("break", r & 32'h4, 32'h4);
		apb(1'h1, A_FIFO, 8'h03);
		apb(1'h1, A_LINE, 8'h00);
		uhrp_peer_i.send(8'hFF, 1'h0);
		apb(1'h0, A_DATA, 8'h00);
		chk("short rx", r, 32'h1F);
		apb(1'h1, A_LINE, 8'h03);
		apb(1'h1, A_IEN, 8'h01);
		apb(1'h1, A_STAT, 8'h3F);
		rx_timeout <= 1'h1;
		@(posedge pclk);
		rx_timeout <= 1'h0;
		apb(1'h0, A_FIFO, 8'h00);
		chk("timeout code", r & 32'hF, 32'hC);
	endtask
	initial begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 10'h000;
		pwdata = 32'h0;
		modem_status = 4'h0;
		presetn = 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		t_map();
		t_tx();
		t_rx();
		t_irq();
		t_err();
		give_verdict();
	end
endmodule // uart_host_register_port_test
`default_nettype wire
